// File: core/pressure_dsp_pkg.sv
package pressure_dsp_pkg;
  // self-test select codes
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_CM = 4'h1;
  localparam logic [3:0] SEL_FIX0 = 4'h4;
  localparam logic [3:0] SEL_FIX3 = 4'h7;
  localparam logic [3:0] SEL_DIG0 = 4'hC;
  localparam logic [3:0] SEL_DIG3 = 4'hF;
  localparam logic [15:0] DIG_ABS1 = 16'h8171;
  localparam logic [15:0] DIG_ABS2 = 16'h6C95;
  localparam logic [15:0] DIG_ABS3 = 16'h807A;
  localparam logic [15:0] DIG_ABS4 = 16'h78AC;
  localparam logic [15:0] DIG_REL = 16'h8001;
  localparam logic [15:0] FIX_V0 = 16'h0000;
  localparam logic [15:0] FIX_V1 = 16'hAAAA;
  localparam logic [15:0] FIX_V2 = 16'h5555;
  localparam logic [15:0] FIX_V3 = 16'hFFFF;
  localparam int DECIM = 48;
  localparam int SINC_W = 23;
  localparam int CLK_MHZ = 25;
  localparam int MOD_RATE_MHZ = 1;
  localparam int MOD_DIV = CLK_MHZ / MOD_RATE_MHZ;
  localparam int SEL_RST = 0;
  localparam int FAIL_RST = 0;
  localparam int RETRY_DEF = 3;
  // automatic self-test timing in microseconds
  localparam int ST_START_US = 1000;
  localparam int ST_ITER_US = 2000;
  localparam int P0INIT_US = 3000;
  localparam int ST_START_CYC = ST_START_US * CLK_MHZ;
  localparam int ST_ITER_CYC = ST_ITER_US * CLK_MHZ;
  localparam int P0INIT_CYC = P0INIT_US * CLK_MHZ;
endpackage

// File: core/pressure_dsp_selftest_chain.sv
// What this block does
// - digital tests one to three force sinc output giving 8171h, 6C95h, 807Ah
// - digital test four gives 78ACh; relative result 8001h; constant output
// - running flag set while any digital or fixed-value test is selected
// - digital and fixed selections accepted only while lock bit clear
// - fixed codes block writes, force 0000h, AAAAh, 5555h, FFFFh
// - serial bus mode runs common-mode and digital tests automatically
// - auto test starts after fixed delay; each iteration bounded in time
// - failed iteration repeats up to retry limit
// - running flag clears on pass or when retries exhausted
// - final pass clears fail flag
// - final failure sets fail flag, init error, error message
// - auto-test fail flag sticks until device reset
// - afterwards average-pressure startup returns to phase one, then inits
// - modulator bit stream enters at 1 MHz
// - one sinc3 filter decimates by 48, top 16 of its 23 bits kept (divide by 128)
// - trim adds offset, pressure powers, temperature terms and cross term
// - four-bit select field picks the self-test
// - lock forces select to 0000 and blocks writes until reset
module pressure_dsp_selftest_chain
  import pressure_dsp_pkg::*;
#(
  parameter int RETRIES = RETRY_DEF,
  parameter int START_CYC = ST_START_CYC,
  parameter int ITER_CYC = ST_ITER_CYC,
  parameter int P0_CYC = P0INIT_CYC,
  parameter logic [15:0] CAL_OFS = 16'h0000,
  parameter logic [15:0] CAL_P = 16'h0001,
  parameter logic [15:0] CAL_PP = 16'h0000,
  parameter logic [15:0] CAL_PPP = 16'h0000,
  parameter logic [15:0] CAL_T = 16'h0000,
  parameter logic [15:0] CAL_TT = 16'h0000,
  parameter logic [15:0] CAL_PT = 16'h0000,
  parameter logic [15:0] TEMP_AMB = 16'h0000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // modulator and temperature
  input wire logic mod_bit,
  input wire logic [15:0] temp_value,
  // configuration
  input wire logic [3:0] selftest_select_wdata,
  input wire logic selftest_select_we,
  input wire logic init_complete_lock_set,
  input wire logic serial_bus_mode,
  input wire logic [1:0] result_kind_select,
  input wire logic cm_test_pass,
  // status
  output logic [3:0] selftest_select,
  output logic init_complete_lock,
  output logic selftest_running,
  output logic selftest_fail,
  output logic init_error,
  output logic send_error_msg,
  output logic avg_pressure_restart,
  output logic avg_pressure_init,
  // results
  output logic [15:0] sensor_result_word,
  output logic [15:0] relative_result_word,
  output logic result_valid
);
  initial begin
    if (RETRIES < 0 || RETRIES > 255 || START_CYC < 1 || ITER_CYC < 2 ||
        P0_CYC < 2 || MOD_DIV < 2 || MOD_DIV > 32) $error("bad parameters");
  end
  typedef enum logic [2:0] {
    A_IDLE, A_WAIT, A_RUN, A_P0, A_DONE
  } auto_t;
  typedef struct packed {
    logic m1, m2;
    logic [4:0] div;
    logic bvld;
    logic [3:0] sel;
    logic lock;
    logic run, fail, ierr, emsg, p0rst, p0ini;
    auto_t st;
    logic [31:0] tmr;
    logic [7:0] tries;
    logic [15:0] res, rel;
    logic rvld;
  } state_t;
  state_t s_q, s_d;
  logic [SINC_W-1:0] sinc_w;
  logic sinc_v;
  sinc3_decim #(.RATIO(DECIM), .W(SINC_W)) u_sinc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .bit_in(s_q.m2),
    .bit_valid(s_q.bvld),
    .word_out(sinc_w),
    .word_valid(sinc_v)
  );
  logic [15:0] tin, dt, trim;
  logic [31:0] acc;
  logic dig, fix, auto_dig, iter_ok;
  logic [1:0] idx;
  always_comb begin
    s_d = s_q;
    s_d.m1 = mod_bit;
    s_d.m2 = s_q.m1;
    s_d.bvld = 1'b0;
    s_d.rvld = 1'b0;
    s_d.p0rst = 1'b0;
    // divide core clock to the modulator sample rate
    if (s_q.div == 5'(MOD_DIV - 1)) begin
      s_d.div = '0;
      s_d.bvld = 1'b1;
    end else begin
      s_d.div = s_q.div + 5'h01;
    end
    // lock is one-way until reset
    if (init_complete_lock_set) s_d.lock = 1'b1;
    if (s_q.lock) begin
      s_d.sel = SEL_NONE;
    end else if (selftest_select_we) begin
      s_d.sel = selftest_select_wdata;
    end
    idx = s_q.sel[1:0];
    dig = s_q.sel[3:2] == 2'b11;
    fix = s_q.sel[3:2] == 2'b01;
    auto_dig = s_q.st == A_RUN;
    // scale by 1/128: top 16 of the 23-bit filter word
    tin = sinc_w[SINC_W-1 -: 16];
    dt = temp_value - TEMP_AMB;
    acc = 32'(CAL_OFS) + 32'(CAL_P * tin) + 32'(CAL_PP * tin * tin) +
      32'(CAL_PPP * tin * tin * tin) + 32'(CAL_T * dt) +
      32'(CAL_TT * dt * dt) + 32'(CAL_PT * tin * dt);
    trim = acc[15:0];
    if (sinc_v) begin
      s_d.rvld = 1'b1;
      if (fix) begin
        // processor result is dropped while the fixed pattern holds
        case (idx)
          2'd0: s_d.res = FIX_V0;
          2'd1: s_d.res = FIX_V1;
          2'd2: s_d.res = FIX_V2;
          default: s_d.res = FIX_V3;
        endcase
        s_d.rel = s_d.res;
      end else if (dig || auto_dig) begin
        // forced sinc value: chain output is constant by construction
        case (auto_dig ? 2'd0 : idx)
          2'd0: s_d.res = DIG_ABS1;
          2'd1: s_d.res = DIG_ABS2;
          2'd2: s_d.res = DIG_ABS3;
          default: s_d.res = DIG_ABS4;
        endcase
        s_d.rel = DIG_REL;
      end else begin
        s_d.res = trim;
        s_d.rel = trim - s_q.res;
      end
    end
    // digital check in auto mode: forced value must reach the result
    iter_ok = cm_test_pass && (s_q.res == DIG_ABS1) && (s_q.rel == DIG_REL);
    case (s_q.st)
      A_IDLE: begin
        if (serial_bus_mode) begin
          s_d.st = A_WAIT;
          s_d.tmr = '0;
        end
      end
      A_WAIT: begin
        s_d.tmr = s_q.tmr + 32'h1;
        if (s_q.tmr == 32'(START_CYC - 1)) begin
          s_d.st = A_RUN;
          s_d.tmr = '0;
          s_d.tries = '0;
        end
      end
      A_RUN: begin
        s_d.tmr = s_q.tmr + 32'h1;
        if (s_q.tmr == 32'(ITER_CYC - 1)) begin
          s_d.tmr = '0;
          if (iter_ok) begin
            s_d.fail = 1'b0;
            s_d.st = A_P0;
            s_d.p0rst = 1'b1;
          end else if (s_q.tries == 8'(RETRIES)) begin
            s_d.fail = 1'b1;
            s_d.ierr = 1'b1;
            s_d.emsg = 1'b1;
            s_d.st = A_P0;
            s_d.p0rst = 1'b1;
          end else begin
            s_d.tries = s_q.tries + 8'h01;
          end
        end
      end
      A_P0: begin
        // average filter restarts at phase one then initializes
        s_d.tmr = s_q.tmr + 32'h1;
        if (s_q.tmr == 32'(P0_CYC - 1)) s_d.st = A_DONE;
      end
      A_DONE: begin
      end
      default: s_d.st = A_IDLE;
    endcase
    s_d.p0ini = s_d.st == A_P0;
    // fail flag never cleared later: only reset does that
    s_d.run = dig || fix || s_d.st == A_RUN;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.st <= A_IDLE;
    end else begin
      s_q <= s_d;
    end
  end
  assign selftest_select = s_q.sel;
  assign init_complete_lock = s_q.lock;
  assign selftest_running = s_q.run;
  assign selftest_fail = s_q.fail;
  assign init_error = s_q.ierr;
  assign send_error_msg = s_q.emsg;
  assign avg_pressure_restart = s_q.p0rst;
  assign avg_pressure_init = s_q.p0ini;
  assign sensor_result_word = s_q.res;
  assign relative_result_word = s_q.rel;
  assign result_valid = s_q.rvld;

  property p_lock_clears;
    @(posedge core_clk) disable iff (sys_rst)
      init_complete_lock |=> selftest_select == 4'h0;
  endproperty
  a_lock_clears: assert property (p_lock_clears)
    else $error("select not cleared under lock");
  property p_lock_sticky;
    @(posedge core_clk) disable iff (sys_rst)
      init_complete_lock |=> init_complete_lock;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock dropped");
  property p_run_sel;
    @(posedge core_clk) disable iff (sys_rst)
      selftest_select[2] |=> selftest_running;
  endproperty
  a_run_sel: assert property (p_run_sel)
    else $error("running flag missing");
  property p_fix_val;
    @(posedge core_clk) disable iff (sys_rst)
      (result_valid && s_q.sel == 4'h5 && $past(s_q.sel) == 4'h5) |->
        sensor_result_word == 16'hAAAA;
  endproperty
  a_fix_val: assert property (p_fix_val)
    else $error("fixed pattern wrong");
  property p_dig_val;
    @(posedge core_clk) disable iff (sys_rst)
      (result_valid && s_q.sel == 4'hF && $past(s_q.sel) == 4'hF &&
       $past(s_q.st) != A_RUN) |-> sensor_result_word == 16'h78AC &&
        relative_result_word == 16'h8001;
  endproperty
  a_dig_val: assert property (p_dig_val)
    else $error("digital test value wrong");
  property p_fail_sticky;
    @(posedge core_clk) disable iff (sys_rst)
      selftest_fail |=> selftest_fail;
  endproperty
  a_fail_sticky: assert property (p_fail_sticky)
    else $error("fail flag cleared");
  property p_fail_msg;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(selftest_fail) |-> init_error && send_error_msg;
  endproperty
  a_fail_msg: assert property (p_fail_msg)
    else $error("fail without error exit");
  property p_p0_restart;
    @(posedge core_clk) disable iff (sys_rst)
      avg_pressure_restart |=> avg_pressure_init;
  endproperty
  a_p0_restart: assert property (p_p0_restart)
    else $error("average filter not initialized");
  property p_sample_rate;
    @(posedge core_clk) disable iff (sys_rst)
      s_q.bvld |=> !s_q.bvld [*2];
  endproperty
  a_sample_rate: assert property (p_sample_rate)
    else $error("sample strobe too fast");
  // iteration timer must never run past its budget
  property p_iter_bound;
    @(posedge core_clk) disable iff (sys_rst)
      s_q.st == A_RUN |-> s_q.tmr < 32'(ITER_CYC);
  endproperty
  a_iter_bound: assert property (p_iter_bound)
    else $error("iteration overran its time");
  property p_retry_cap;
    @(posedge core_clk) disable iff (sys_rst)
      s_q.st == A_RUN |-> s_q.tries <= 8'(RETRIES);
  endproperty
  a_retry_cap: assert property (p_retry_cap)
    else $error("retry count beyond limit");
  // a manual selection may keep the flag up, so only check without one
  property p_run_ends;
    @(posedge core_clk) disable iff (sys_rst)
      (avg_pressure_restart && !$past(dig || fix)) |-> !selftest_running;
  endproperty
  a_run_ends: assert property (p_run_ends)
    else $error("running flag kept after auto test");
  c_fail: cover property (@(posedge core_clk) $rose(selftest_fail));
  c_pass: cover property (@(posedge core_clk)
    $fell(selftest_running) && !selftest_fail);
  c_dig: cover property (@(posedge core_clk)
    result_valid && sensor_result_word == 16'h8171);
  c_lock: cover property (@(posedge core_clk) $rose(init_complete_lock));
  c_fix: cover property (@(posedge core_clk)
    result_valid && sensor_result_word == 16'hAAAA);
endmodule

// File: core/sinc3_decim.sv
module sinc3_decim
  import pressure_dsp_pkg::*;
#(
  parameter int RATIO = DECIM,
  parameter int W = SINC_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // bit stream
  input wire logic bit_in,
  input wire logic bit_valid,
  // decimated word
  output logic [W-1:0] word_out,
  output logic word_valid
);
  initial begin
    if (RATIO < 2 || RATIO > 256 || W < 17) $error("sinc3_decim: bad parameters");
  end
  typedef struct packed {
    logic [W-1:0] i1, i2, i3, c1, c2, c3, y;
    logic [7:0] cnt;
    logic vld;
  } sinc_t;
  sinc_t s_q, s_d;
  logic [W-1:0] x, d1, d2, d3;
  always_comb begin
    s_d = s_q;
    s_d.vld = 1'b0;
    x = bit_in ? W'(1) : W'(0);
    d1 = '0;
    d2 = '0;
    d3 = '0;
    if (bit_valid) begin
      s_d.i1 = s_q.i1 + x;
      s_d.i2 = s_q.i2 + s_q.i1;
      s_d.i3 = s_q.i3 + s_q.i2;
      if (s_q.cnt == 8'(RATIO - 1)) begin
        s_d.cnt = '0;
        // wraparound arithmetic keeps the comb exact
        d1 = s_q.i3 - s_q.c1;
        d2 = d1 - s_q.c2;
        d3 = d2 - s_q.c3;
        s_d.c1 = s_q.i3;
        s_d.c2 = d1;
        s_d.c3 = d2;
        s_d.y = d3;
        s_d.vld = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) s_q <= '0;
    else s_q <= s_d;
  end
  assign word_out = s_q.y;
  assign word_valid = s_q.vld;
endmodule

// File: test/mod_source.sv
module mod_source
  import pressure_dsp_pkg::*;
#(
  parameter logic [7:0] LEVEL = 8'h5A
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // bit stream
  output logic mod_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] div_q;
  logic [8:0] acc_q;
  // first-order shaping stands in for the analog loop: density LEVEL/256
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_q <= 5'h00;
      acc_q <= 9'h000;
    end else if (div_q == 5'(MOD_DIV - 1)) begin
      div_q <= 5'h00;
      acc_q <= {1'b0, acc_q[7:0]} + {1'b0, LEVEL};
    end else begin
      div_q <= div_q + 5'h01;
    end
  end
  assign mod_bit = acc_q[8];
endmodule

// File: test/tb_pressure_dsp_selftest_chain.sv
module tb_pressure_dsp_selftest_chain;
  import pressure_dsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RT = 2;
  localparam int ST = 40;
  localparam int IT = 3000;
  localparam int P0 = 20;
  localparam logic [7:0] LVL = 8'h5A;
  localparam int SPAN = ST + (RT + 1) * IT + P0 + 200;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mod_bit;
  logic [15:0] temp_value = 16'h0000;
  logic [3:0] selftest_select_wdata = 4'h0;
  logic selftest_select_we = 1'b0;
  logic init_complete_lock_set = 1'b0;
  logic serial_bus_mode = 1'b0;
  logic [1:0] result_kind_select = 2'h0;
  logic cm_test_pass = 1'b0;
  logic [3:0] selftest_select;
  logic init_complete_lock, selftest_running, selftest_fail, init_error;
  logic send_error_msg, avg_pressure_restart, avg_pressure_init;
  logic [15:0] sensor_result_word, relative_result_word;
  logic result_valid;
  logic [15:0] dig_exp [4] = '{DIG_ABS1, DIG_ABS2, DIG_ABS3, DIG_ABS4};
  logic [15:0] fix_exp [4] = '{FIX_V0, FIX_V1, FIX_V2, FIX_V3};
  int fails = 0;
  int checked = 0;
  int seed = 73248;
  int k;

  always #20 core_clk = ~core_clk;

  pressure_dsp_selftest_chain #(.RETRIES(RT), .START_CYC(ST), .ITER_CYC(IT),
    .P0_CYC(P0)) pressure_dsp_selftest_chain_inst (.core_clk, .sys_rst,
    .mod_bit, .temp_value, .selftest_select_wdata, .selftest_select_we,
    .init_complete_lock_set, .serial_bus_mode, .result_kind_select,
    .cm_test_pass, .selftest_select, .init_complete_lock, .selftest_running,
    .selftest_fail, .init_error, .send_error_msg, .avg_pressure_restart,
    .avg_pressure_init, .sensor_result_word, .relative_result_word,
    .result_valid);
  mod_source #(.LEVEL(LVL)) mod_source_inst (.core_clk, .sys_rst, .mod_bit);

  // random temperature shows the forced results do not move with it
  always @(posedge core_clk) temp_value <= 16'($random(seed));

  task automatic chk16(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  // density LVL/256 through a gain of 48 cubed, top 16 bits kept
  function automatic logic in_band(input logic [15:0] v);
    int e;
    e = (int'(LVL) * DECIM * DECIM * DECIM / 256) >> (SINC_W - 16);
    return int'(v) > e - 32 && int'(v) < e + 32;
  endfunction

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_reset;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    serial_bus_mode <= 1'b0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic sel_write(input logic [3:0] v);
    @(posedge core_clk);
    selftest_select_wdata <= v;
    selftest_select_we <= 1'b1;
    @(posedge core_clk);
    selftest_select_we <= 1'b0;
    #1;
  endtask

  // first word after a change may still carry the old setting
  task automatic wait_word(input int words);
    int n;
    n = 0;
    repeat (words) begin
      do begin
        @(posedge core_clk);
        #1;
        n++;
      end while (result_valid !== 1'b1 && n < 1300 * words);
    end
    if (n >= 1300 * words) chk1("result_valid", 1'b1, result_valid);
  endtask

  task automatic auto_run(input logic pass);
    int fall, rs, ini;
    logic seen;
    fall = 0;
    rs = 0;
    ini = 0;
    seen = 1'b0;
    @(posedge core_clk);
    cm_test_pass <= pass;
    serial_bus_mode <= 1'b1;
    for (int c = 0; c < SPAN; c++) begin
      @(posedge core_clk);
      #1;
      if (selftest_running === 1'b1) seen = 1'b1;
      if (seen && selftest_running === 1'b0 && fall == 0) fall = c;
      if (avg_pressure_restart === 1'b1) rs++;
      if (avg_pressure_init === 1'b1) ini++;
    end
    chk1("selftest_ran", 1'b1, seen);
    chk1("selftest_running", 1'b0, selftest_running);
    chk1("selftest_fail", !pass, selftest_fail);
    chk1("init_error", !pass, init_error);
    chk1("send_error_msg", !pass, send_error_msg);
    chk16("restart_pulses", 16'h0001, 16'(rs));
    chk16("p0_init_cycles", 16'(P0), 16'(ini));
    if (pass)
      chk16("iter_end", 16'(ST + IT), 16'(fall));
    else
      chk16("retry_end", 16'(ST + (RT + 1) * IT), 16'(fall));
    $display("test auto self-test pass=%b done", pass);
  endtask

  initial begin
    repeat (80000) @(posedge core_clk);
    fails++;
    report_and_stop;
  end

  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk16("selftest_select", 16'h0000, {12'h000, selftest_select});
    chk1("selftest_fail", 1'b0, selftest_fail);
    $display("test reset done");
    wait_word(4);
    chk1("trim_result", 1'b1, in_band(sensor_result_word));
    $display("test trim done");
    k = $unsigned($random(seed)) % 4;
    for (int i = 0; i < 4; i++) begin
      sel_write(SEL_DIG0 + 4'((i + k) % 4));
      chk16("selftest_select", 16'(SEL_DIG0 + (i + k) % 4),
        {12'h000, selftest_select});
      @(posedge core_clk);
      #1;
      chk1("selftest_running", 1'b1, selftest_running);
      wait_word(2);
      chk16("abs_result", dig_exp[(i + k) % 4], sensor_result_word);
      chk16("rel_result", DIG_REL, relative_result_word);
      wait_word(1);
      chk16("abs_again", dig_exp[(i + k) % 4], sensor_result_word);
    end
    $display("test digital done");
    for (int i = 0; i < 4; i++) begin
      sel_write(SEL_FIX0 + 4'(i));
      @(posedge core_clk);
      #1;
      chk1("selftest_running", 1'b1, selftest_running);
      wait_word(2);
      chk16("abs_fixed", fix_exp[i], sensor_result_word);
      chk16("rel_fixed", fix_exp[i], relative_result_word);
    end
    $display("test fixed done");
    sel_write(SEL_DIG0);
    @(posedge core_clk);
    init_complete_lock_set <= 1'b1;
    @(posedge core_clk);
    init_complete_lock_set <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk1("init_complete_lock", 1'b1, init_complete_lock);
    chk16("selftest_select", 16'h0000, {12'h000, selftest_select});
    sel_write(SEL_FIX3);
    repeat (3) @(posedge core_clk);
    #1;
    chk16("selftest_select", 16'h0000, {12'h000, selftest_select});
    chk1("selftest_running", 1'b0, selftest_running);
    $display("test lock done");
    do_reset;
    auto_run(1'b1);
    do_reset;
    auto_run(1'b0);
    @(posedge core_clk);
    serial_bus_mode <= 1'b0;
    cm_test_pass <= 1'b1;
    repeat (100) @(posedge core_clk);
    #1;
    chk1("fail_sticky", 1'b1, selftest_fail);
    do_reset;
    chk1("fail_cleared", 1'b0, selftest_fail);
    $display("test sticky fail done");
    report_and_stop;
  end
endmodule
